// [hdl/thermal_shutdown_cfg.svh]
// Constants for the thermal shutdown and alert logic
`ifndef THERMAL_SHUTDOWN_CFG_SVH
`define THERMAL_SHUTDOWN_CFG_SVH
`define TEMP_WIDTH 11
`define TEMP_FRAC_BITS 3
`define CHANNEL_COUNT 5
`define HYST_DEGREES 10
`define HYST_CODE 11'h050
`define CONSEC_DEFAULT 3'h4
`define CONSEC_WIDTH 3
`define DECODE_SETTLE_CYCLES 8'h10
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_MASK 12'h008
`define ADDR_CONSEC 12'h00c
`define ADDR_SHDN_SEL 12'h010
`define ADDR_THRESH 12'h014
`define ADDR_TEMP_BASE 12'h020
`define ADDR_ALERT_BASE 12'h040
`define ADDR_THERM_BASE 12'h060
`define CTRL_STANDBY_BIT 0
`define CTRL_ONESHOT_BIT 1
`define CTRL_ALERT_MASK_BIT 2
`define CTRL_SHDN_FUNC_BIT 3
`define STAT_SHDN_BIT 0
`define STAT_THERM_BIT 1
`define STAT_ALERT_BIT 2
`define STAT_REFUSE_BIT 3
`define STAT_WIDTH 4
`define LIMIT_RESET 11'h7ff
`endif

// [hdl/thermal_shutdown_pkg.sv]
// Types for the thermal shutdown and alert logic
package thermal_shutdown_pkg;
  typedef struct packed {
    logic [10:0] temp;
    logic [2:0] channel;
    logic valid;
  } measurement_type;
  typedef struct packed {
    logic standby;
    logic oneShot;
    logic alertMask;
    logic shdnFunc;
  } ctrl_type;
  typedef enum logic [1:0] {
    DECODE_WAIT = 2'b00,
    DECODE_SAMPLE = 2'b01,
    DECODE_DONE = 2'b10
  } decode_state_type;
endpackage : thermal_shutdown_pkg

// [hdl/thermal_shutdown_alert_logic.sv]
// Thermal shutdown, therm and maskable alert logic with APB registers
//
// Notes on behaviour
// R1 - Shutdown threshold decoded from two pin straps
// R2 - Refuse standby/one-shot when shutdown function set
// R3 - Compare each diode 1 measurement with threshold
// R4 - Shutdown consecutive counter, default four
// R5 - Assert shutdown after enough consecutive qualifying readings
// R6 - Release shutdown below threshold minus ten degrees
// R7 - Every channel may drive shutdown
// R8 - Enabled channel drives shutdown at or above therm limit
// R9 - Maskable alert when temperature exceeds alert limit
// R10 - Therm-tier output at or above limit, unmasked
// R11 - Temperatures are 11-bit, 0.125 degree steps
// R12 - Counter clears on reading below threshold
`timescale 1ns/10ps
`include "thermal_shutdown_cfg.svh"

module thermal_shutdown_alert_logic #(
  parameter int CHANNELS = `CHANNEL_COUNT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurements from the converter
  input wire thermal_shutdown_pkg::measurement_type measIn,
  // Strap codes sensed on the two pull-up pins
  input wire logic [2:0] shdnStrapCode,
  input wire logic [2:0] alertStrapCode,
  // Open-drain outputs, enable low while pulling low
  output logic systemShutdownOutOe_n,
  output logic maskableAlertOutOe_n,
  output logic thermTierOutOe_n,
  // Interrupt
  output logic irq
);

  // Strap decode: 60 + 8 x shutdown strap + alert strap degrees, returned as an 11-bit code
  function automatic logic [10:0] decodeThreshold(input logic [2:0] s, input logic [2:0] a);
    logic [7:0] deg;
    deg = 8'h3c + {2'h0, s, 3'h0} + {5'h0, a};
    return {deg, 3'h0};
  endfunction : decodeThreshold

  // Limit compare helper on 11-bit codes
  function automatic logic atOrAbove(input logic [10:0] t, input logic [10:0] lim);
    return t >= lim;
  endfunction : atOrAbove

  // Strap decode state
  thermal_shutdown_pkg::decode_state_type decState_reg, decState_next;
  logic [7:0] settle_reg, settle_next;
  logic [10:0] thresh_reg, thresh_next;

  // Register file
  thermal_shutdown_pkg::ctrl_type ctrl_reg, ctrl_next;
  logic [`STAT_WIDTH-1:0] status_reg, status_next, mask_reg, mask_next;
  logic [`CONSEC_WIDTH-1:0] consecLimit_reg, consecLimit_next;
  logic [CHANNELS-1:0] shdnSel_reg, shdnSel_next;
  logic [10:0] temp_reg [CHANNELS];
  logic [10:0] alertLim_reg [CHANNELS];
  logic [10:0] thermLim_reg [CHANNELS];

  // Shutdown and tier state
  logic [`CONSEC_WIDTH-1:0] consec_reg, consec_next;
  logic hwShdn_reg, hwShdn_next;
  logic [CHANNELS-1:0] thermCh_reg, thermCh_next;
  logic [CHANNELS-1:0] alertCh_reg, alertCh_next;
  logic shdnOut_reg, alertOut_reg, thermOut_reg;
  logic shdnOut_next, alertOut_next, thermOut_next;

  logic wrEn, rdEn, accessOk;
  logic [11:0] chanOff;
  logic [2:0] chanIdx;
  logic [3:0] events;
  logic refuse;

  // Strap decode sequence after reset
  always_comb begin
    decState_next = decState_reg;
    settle_next = settle_reg;
    thresh_next = thresh_reg;
    case (decState_reg)
      thermal_shutdown_pkg::DECODE_WAIT: begin
        if (settle_reg == `DECODE_SETTLE_CYCLES) begin
          decState_next = thermal_shutdown_pkg::DECODE_SAMPLE;
        end else begin
          settle_next = settle_reg + 8'h01;
        end
      end
      thermal_shutdown_pkg::DECODE_SAMPLE: begin
        thresh_next = decodeThreshold(shdnStrapCode, alertStrapCode); // [R1]
        decState_next = thermal_shutdown_pkg::DECODE_DONE;
      end
      thermal_shutdown_pkg::DECODE_DONE: begin
        decState_next = decState_reg;
      end
      default: begin
        decState_next = thermal_shutdown_pkg::DECODE_WAIT;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      decState_reg <= thermal_shutdown_pkg::DECODE_WAIT;
      settle_reg <= 8'h00;
      thresh_reg <= `LIMIT_RESET;
    end else begin
      decState_reg <= decState_next;
      settle_reg <= settle_next;
      thresh_reg <= thresh_next;
    end
  end

  // APB decode, zero-wait answer
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign chanOff = paddr & 12'hfe3;
  assign chanIdx = paddr[4:2];
  assign accessOk = (paddr <= `ADDR_THRESH) || (chanIdx < CHANNELS &&
    (chanOff == `ADDR_TEMP_BASE || chanOff == `ADDR_ALERT_BASE ||
     chanOff == `ADDR_THERM_BASE));
  assign pslverr = psel && penable && !accessOk;
  assign refuse = wrEn && paddr == `ADDR_CTRL && pwdata[`CTRL_SHDN_FUNC_BIT] &&
    (pwdata[`CTRL_STANDBY_BIT] || pwdata[`CTRL_ONESHOT_BIT]);

  // Shutdown counter, hysteresis and tier outputs
  always_comb begin
    logic [10:0] release_lim;
    release_lim = (thresh_reg > `HYST_CODE) ? thresh_reg - `HYST_CODE : 11'h000;
    consec_next = consec_reg;
    hwShdn_next = hwShdn_reg;
    thermCh_next = thermCh_reg;
    alertCh_next = alertCh_reg;
    if (measIn.valid && measIn.channel < CHANNELS) begin
      // 11-bit codes, 0.125 degree lsb
      thermCh_next[measIn.channel] = atOrAbove(measIn.temp, thermLim_reg[measIn.channel]); // [R10] [R11]
      alertCh_next[measIn.channel] = measIn.temp > alertLim_reg[measIn.channel]; // [R9]
      if (measIn.channel == 3'h0 && decState_reg == thermal_shutdown_pkg::DECODE_DONE) begin
        if (atOrAbove(measIn.temp, thresh_reg)) begin // [R3]
          if (consec_reg + 3'h1 >= consecLimit_reg) begin
            hwShdn_next = 1'b1; // [R5]
          end else begin
            consec_next = consec_reg + 3'h1; // [R4]
          end
        end else begin
          consec_next = 3'h0; // [R12]
          if (measIn.temp < release_lim) begin
            hwShdn_next = 1'b0; // [R6]
          end
        end
      end
    end
    thermOut_next = |thermCh_next;
    shdnOut_next = hwShdn_next || |(thermCh_next & shdnSel_reg); // [R7] [R8]
    alertOut_next = |alertCh_next && !ctrl_reg.alertMask; // [R9]
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      consec_reg <= 3'h0;
      hwShdn_reg <= 1'b0;
      thermCh_reg <= '0;
      alertCh_reg <= '0;
      thermOut_reg <= 1'b0;
      shdnOut_reg <= 1'b0;
      alertOut_reg <= 1'b0;
    end else begin
      consec_reg <= consec_next;
      hwShdn_reg <= hwShdn_next;
      thermCh_reg <= thermCh_next;
      alertCh_reg <= alertCh_next;
      thermOut_reg <= thermOut_next;
      shdnOut_reg <= shdnOut_next;
      alertOut_reg <= alertOut_next;
    end
  end

  assign systemShutdownOutOe_n = !shdnOut_reg;
  assign maskableAlertOutOe_n = !alertOut_reg;
  assign thermTierOutOe_n = !thermOut_reg;

  // Sticky events: rising edges of outputs and refused mode writes
  assign events = {refuse, alertOut_next & !alertOut_reg,
    thermOut_next & !thermOut_reg, shdnOut_next & !shdnOut_reg};

  // Control, status and mask registers
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    consecLimit_next = consecLimit_reg;
    shdnSel_next = shdnSel_reg;
    status_next = status_reg;
    if (wrEn) begin
      case (paddr)
        `ADDR_CTRL: begin
          if (!refuse) begin
            ctrl_next = {pwdata[`CTRL_STANDBY_BIT], pwdata[`CTRL_ONESHOT_BIT],
              pwdata[`CTRL_ALERT_MASK_BIT], pwdata[`CTRL_SHDN_FUNC_BIT]}; // [R2]
          end
        end
        `ADDR_STATUS: status_next = status_reg & ~pwdata[`STAT_WIDTH-1:0];
        `ADDR_MASK: mask_next = pwdata[`STAT_WIDTH-1:0];
        `ADDR_CONSEC: consecLimit_next = (pwdata[2:0] == 3'h0) ? 3'h1 : pwdata[2:0];
        `ADDR_SHDN_SEL: shdnSel_next = pwdata[CHANNELS-1:0];
        default: ctrl_next = ctrl_reg;
      endcase
    end
    status_next = status_next | events; // set wins over clear
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= '{standby: 1'b0, oneShot: 1'b0, alertMask: 1'b0, shdnFunc: 1'b1};
      mask_reg <= '0;
      consecLimit_reg <= `CONSEC_DEFAULT;
      shdnSel_reg <= '0;
      status_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      consecLimit_reg <= consecLimit_next;
      shdnSel_reg <= shdnSel_next;
      status_reg <= status_next;
    end
  end

  // Per-channel limits and latest temperatures
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < CHANNELS; i++) begin
        temp_reg[i] <= 11'h000;
        alertLim_reg[i] <= `LIMIT_RESET;
        thermLim_reg[i] <= `LIMIT_RESET;
      end
    end else begin
      if (measIn.valid && measIn.channel < CHANNELS) begin
        temp_reg[measIn.channel] <= measIn.temp;
      end
      if (wrEn && chanIdx < CHANNELS) begin
        if (chanOff == `ADDR_ALERT_BASE) begin
          alertLim_reg[chanIdx] <= pwdata[10:0];
        end
        if (chanOff == `ADDR_THERM_BASE) begin
          thermLim_reg[chanIdx] <= pwdata[10:0];
        end
      end
    end
  end

  // Read data registered in the setup cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (rdEn) begin
      prdata <= 32'h00000000;
      case (paddr)
        `ADDR_CTRL: prdata[3:0] <= {ctrl_reg.shdnFunc, ctrl_reg.alertMask,
          ctrl_reg.oneShot, ctrl_reg.standby};
        `ADDR_STATUS: prdata[`STAT_WIDTH-1:0] <= status_reg;
        `ADDR_MASK: prdata[`STAT_WIDTH-1:0] <= mask_reg;
        `ADDR_CONSEC: prdata[2:0] <= consecLimit_reg;
        `ADDR_SHDN_SEL: prdata[CHANNELS-1:0] <= shdnSel_reg;
        `ADDR_THRESH: prdata[10:0] <= thresh_reg;
        default: begin
          if (chanIdx < CHANNELS && chanOff == `ADDR_TEMP_BASE) prdata[10:0] <= temp_reg[chanIdx];
          if (chanIdx < CHANNELS && chanOff == `ADDR_ALERT_BASE) prdata[10:0] <= alertLim_reg[chanIdx];
          if (chanIdx < CHANNELS && chanOff == `ADDR_THERM_BASE) prdata[10:0] <= thermLim_reg[chanIdx];
        end
      endcase
    end
  end

  assign irq = |(status_reg & mask_reg);

  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence hotD1_s;
    measIn.valid && measIn.channel == 3'h0 && measIn.temp >= thresh_reg &&
      decState_reg == thermal_shutdown_pkg::DECODE_DONE;
  endsequence

  refuse_mode_a: assert property (refuse |=> ctrl_reg == $past(ctrl_reg)) // [R2]
    else $error("mode write with shutdown not refused");
  thresh_hold_a: assert property (decState_reg == thermal_shutdown_pkg::DECODE_DONE
    |=> $stable(thresh_reg)) // [R1]
    else $error("threshold changed after decode");
  shdn_assert_a: assert property (hotD1_s ##0 (consec_reg + 3'h1 >= consecLimit_reg)
    |=> ##1 !systemShutdownOutOe_n) // [R5]
    else $error("shutdown not asserted after count");
  count_step_a: assert property (hotD1_s ##0 (consec_reg + 3'h1 < consecLimit_reg)
    |=> consec_reg == $past(consec_reg) + 3'h1) // [R4] [R3]
    else $error("consecutive count did not step");
  count_clear_a: assert property (measIn.valid && measIn.channel == 3'h0 &&
    measIn.temp < thresh_reg |=> consec_reg == 3'h0) // [R12]
    else $error("count not cleared");
  hyst_hold_a: assert property (hwShdn_reg && measIn.valid && measIn.channel == 3'h0 &&
    measIn.temp >= thresh_reg - `HYST_CODE && thresh_reg > `HYST_CODE |=> hwShdn_reg) // [R6]
    else $error("shutdown released inside hysteresis");
  therm_out_a: assert property (measIn.valid && measIn.channel < CHANNELS &&
    measIn.temp >= thermLim_reg[measIn.channel] |=> ##1 !thermTierOutOe_n) // [R10] [R11]
    else $error("therm output missing");
  sel_shdn_a: assert property (measIn.valid && measIn.channel < CHANNELS &&
    shdnSel_reg[measIn.channel] && measIn.temp >= thermLim_reg[measIn.channel]
    |=> ##1 !systemShutdownOutOe_n) // [R7] [R8]
    else $error("selected channel did not drive shutdown");
  alert_mask_a: assert property (ctrl_reg.alertMask |=> maskableAlertOutOe_n) // [R9]
    else $error("alert not masked");

endmodule : thermal_shutdown_alert_logic

// [verification/far_side_model.sv]
// Converter, strap and pull-up model on the far side of the thermal block
`timescale 1ns/10ps
module far_side_model #(
  parameter logic [2:0] SHDN_STRAP = 3'h2,
  parameter logic [2:0] ALERT_STRAP = 3'h1
) (
  // Clock
  input wire logic sys_clk,
  // Measurement stream into the block
  output thermal_shutdown_pkg::measurement_type measIn,
  // Strap levels seen through the pull-up resistors
  output logic [2:0] shdnStrapCode,
  output logic [2:0] alertStrapCode,
  // Open-drain enables and resolved pin levels
  input wire logic systemShutdownOutOe_n,
  input wire logic maskableAlertOutOe_n,
  input wire logic thermTierOutOe_n,
  output logic shutdownLine,
  output logic alertLine,
  output logic thermLine
);
  // Pull-ups hold each line high unless the block pulls it low
  assign shutdownLine = systemShutdownOutOe_n ? 1'b1 : 1'b0;
  assign alertLine = maskableAlertOutOe_n ? 1'b1 : 1'b0;
  assign thermLine = thermTierOutOe_n ? 1'b1 : 1'b0;
  // Board straps select the shutdown threshold
  assign shdnStrapCode = SHDN_STRAP;
  assign alertStrapCode = ALERT_STRAP;
  initial measIn = '0;

  // One measurement pulse, stale data inverted after it, then settle time
  task automatic send(input logic [2:0] ch, input logic [10:0] temp);
    @(posedge sys_clk);
    measIn <= {temp, ch, 1'b1};
    @(posedge sys_clk);
    measIn <= {~temp, ch, 1'b0};
    repeat (2) @(posedge sys_clk);
  endtask : send
endmodule : far_side_model

// [verification/thermal_shutdown_alert_logic_bench.sv]
// Self-checking bench for the thermal shutdown and alert logic
`timescale 1ns/10ps
`include "thermal_shutdown_cfg.svh"
module thermal_shutdown_alert_logic_bench;
  localparam logic [10:0] THR = 11'h268; // 77 degrees from straps 2 and 1
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  thermal_shutdown_pkg::measurement_type measIn;
  logic [2:0] shdnStrapCode;
  logic [2:0] alertStrapCode;
  logic systemShutdownOutOe_n;
  logic maskableAlertOutOe_n;
  logic thermTierOutOe_n;
  logic irq;
  logic shutdownLine;
  logic alertLine;
  logic thermLine;
  logic [31:0] rd;
  logic errSeen;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  thermal_shutdown_alert_logic i_thermal_shutdown_alert_logic (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .measIn(measIn), .shdnStrapCode(shdnStrapCode), .alertStrapCode(alertStrapCode),
    .systemShutdownOutOe_n(systemShutdownOutOe_n), .maskableAlertOutOe_n(maskableAlertOutOe_n),
    .thermTierOutOe_n(thermTierOutOe_n), .irq(irq));

  far_side_model i_far_side_model (
    .sys_clk(sys_clk), .measIn(measIn), .shdnStrapCode(shdnStrapCode),
    .alertStrapCode(alertStrapCode), .systemShutdownOutOe_n(systemShutdownOutOe_n),
    .maskableAlertOutOe_n(maskableAlertOutOe_n), .thermTierOutOe_n(thermTierOutOe_n),
    .shutdownLine(shutdownLine), .alertLine(alertLine), .thermLine(thermLine));

  // Closing report and verdict
  task stop_test;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Registers written at the access edge update after it; check them later
    @(negedge sys_clk);
  endtask : apb

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (20) @(posedge sys_clk);
    apb(`ADDR_THRESH, 1'b0, 32'h0);
    chk(rd, {21'h0, THR});
    apb(`ADDR_CTRL, 1'b1, 32'h9);
    apb(`ADDR_CTRL, 1'b1, 32'ha);
    apb(`ADDR_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h8);
    apb(`ADDR_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h8, 32'h8);
    chk({31'h0, irq}, 32'h0);
    apb(`ADDR_MASK, 1'b1, 32'h8);
    chk({31'h0, irq}, 32'h1);
    apb(`ADDR_STATUS, 1'b1, 32'h8);
    chk({31'h0, irq}, 32'h0);
    apb(12'hffc, 1'b0, 32'h0);
    chk({31'h0, errSeen}, 32'h1);
    // Hot run broken by one cold reading, then four in a row
    repeat (3) i_far_side_model.send(3'h0, THR);
    i_far_side_model.send(3'h0, THR - 11'h1);
    repeat (3) i_far_side_model.send(3'h0, THR);
    chk({31'h0, shutdownLine}, 32'h1);
    i_far_side_model.send(3'h0, THR);
    chk({31'h0, shutdownLine}, 32'h0);
    i_far_side_model.send(3'h0, THR - 11'h50);
    chk({31'h0, shutdownLine}, 32'h0);
    i_far_side_model.send(3'h0, THR - 11'h51);
    chk({31'h0, shutdownLine}, 32'h1);
    // Shorter consecutive limit
    apb(`ADDR_CONSEC, 1'b1, 32'h2);
    i_far_side_model.send(3'h0, THR + 11'h1);
    chk({31'h0, shutdownLine}, 32'h1);
    i_far_side_model.send(3'h0, THR + 11'h1);
    chk({31'h0, shutdownLine}, 32'h0);
    i_far_side_model.send(3'h0, 11'h0);
    // Therm tier and channel-selected shutdown
    apb(`ADDR_THERM_BASE + 12'h8, 1'b1, 32'h100);
    i_far_side_model.send(3'h2, 11'h101);
    chk({31'h0, thermLine}, 32'h0);
    chk({31'h0, shutdownLine}, 32'h1);
    apb(`ADDR_SHDN_SEL, 1'b1, 32'h4);
    i_far_side_model.send(3'h2, 11'h100);
    chk({31'h0, thermLine}, 32'h0);
    i_far_side_model.send(3'h2, 11'h101);
    chk({31'h0, shutdownLine}, 32'h0);
    i_far_side_model.send(3'h2, 11'h0ff);
    chk({31'h0, thermLine}, 32'h1);
    chk({31'h0, shutdownLine}, 32'h1);
    // Maskable alert
    apb(`ADDR_ALERT_BASE + 12'h4, 1'b1, 32'h200);
    i_far_side_model.send(3'h1, 11'h200);
    chk({31'h0, alertLine}, 32'h1);
    i_far_side_model.send(3'h1, 11'h201);
    chk({31'h0, alertLine}, 32'h0);
    apb(`ADDR_TEMP_BASE + 12'h4, 1'b0, 32'h0);
    chk(rd, 32'h201);
    apb(`ADDR_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h4, 32'h4);
    apb(`ADDR_CTRL, 1'b1, 32'hc);
    i_far_side_model.send(3'h1, 11'h201);
    chk({31'h0, alertLine}, 32'h1);
    stop_test();
  end
endmodule : thermal_shutdown_alert_logic_bench
